/* cftt_defines.svh */
// register offsets, field positions and widths of the transmit frame tail block
`ifndef CFTT_DEFINES_SVH
`define CFTT_DEFINES_SVH
`define CFTT_ADDR_W 8
`define CFTT_OFS_PAY_45_48 8'h3c
`define CFTT_OFS_PAY_49_52 8'h40
`define CFTT_OFS_PAY_53_56 8'h44
`define CFTT_OFS_PAY_57_60 8'h48
`define CFTT_OFS_PAY_61_64 8'h4c
`define CFTT_OFS_ERR_INJ 8'h50
`define CFTT_OFS_STATUS 8'h54
`define CFTT_PAY_WORDS 5
`define CFTT_FIRST_BYTE 6'h2c
`define CFTT_LAST_BYTE 6'h3f
`define CFTT_WORD_SWIZZLED 3'h2
`define CFTT_BIT_STC_FLIP 0
`define CFTT_BIT_CRC_FLIP 1
`define CFTT_BIT_DLC_SWAP 2
`define CFTT_PRM_LSB 8
`define CFTT_PRM_MSB 12
`define CFTT_STC_W 4
`define CFTT_CRC_W 21
`define CFTT_DLC_W 4
`define CFTT_CRC_W_5 5'h15
`define CFTT_CNT_W 8
`endif

/* cftt_pkg.sv */
// types shared by the transmit frame tail block
package cftt_pkg;
  typedef struct packed {
    logic [4:0] injection_parameter;
    logic length_code_swap;
    logic crc_bit_flip;
    logic stuff_count_flip;
  } cftt_inject_t;

  typedef struct packed {
    logic [3:0] stuff_count;
    logic [20:0] crc;
    logic [3:0] dlc;
  } cftt_fields_t;

  typedef enum logic [1:0] {
    CFTT_IDLE,
    CFTT_TX_FRAME,
    CFTT_RX_FRAME
  } cftt_state_t;
endpackage

/* cftt_frame_tail.sv */
// transmit frame tail: payload bytes 45..64 and frame error injection
// Contract
// - bytes 45..48 at 0x3c, 49..52 at 0x40, ascending lanes from bits 7:0
// - word 0x44 lanes: byte 53, 56, 55, 54 from bits 7:0 upward
// - bytes 57..60 at 0x48, lowest in bits 7:0, highest in 31:24
// - bytes 61..64 at 0x4c, byte 61 in bits 7:0, ascending lanes
// - stuff count flip bit inverts one stuff count bit, transmitted frames only
// - crc flip bit inverts one crc bit, transmitted frames only
// - length code swap sends a substituted dlc instead of the stored one
`include "cftt_defines.svh"
module cftt_frame_tail
#(
  parameter int ADDR_W = `CFTT_ADDR_W
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frm_start,
  input wire logic frm_is_tx,
  input wire logic frm_end,
  input wire logic byte_req,
  input wire logic [5:0] byte_idx,
  output logic byte_valid,
  output logic byte_hit,
  output logic [7:0] byte_data,
  input wire logic fld_valid,
  input wire cftt_pkg::cftt_fields_t fld_in,
  output logic fld_out_valid,
  output cftt_pkg::cftt_fields_t fld_out
);
  logic [31:0] pay_mem [`CFTT_PAY_WORDS];
  cftt_pkg::cftt_inject_t inj_ff;
  cftt_pkg::cftt_inject_t snap_ff;
  cftt_pkg::cftt_state_t state_ff;
  cftt_pkg::cftt_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic byte_valid_ff;
  logic byte_hit_ff;
  logic [7:0] byte_data_ff;
  logic fld_valid_ff;
  cftt_pkg::cftt_fields_t fld_ff;
  logic last_inj_ff;
  logic [`CFTT_CNT_W-1:0] inj_cnt_ff;

  // register decode
  wire sel_pay = (reg_addr >= ADDR_W'(`CFTT_OFS_PAY_45_48)) &&
                 (reg_addr <= ADDR_W'(`CFTT_OFS_PAY_61_64)) && (reg_addr[1:0] == 2'h0);
  wire [ADDR_W-1:0] pay_rel = reg_addr - ADDR_W'(`CFTT_OFS_PAY_45_48);
  wire [2:0] pay_wsel = pay_rel[4:2];
  wire sel_inj = (reg_addr == ADDR_W'(`CFTT_OFS_ERR_INJ));
  wire sel_sts = (reg_addr == ADDR_W'(`CFTT_OFS_STATUS));
  wire wr_pay = reg_wr && sel_pay;
  wire wr_inj = reg_wr && sel_inj;
  wire [1:0] frm_state_bits = state_ff;
  wire [31:0] sts_word = {16'h0000, inj_cnt_ff, 4'h0, frm_state_bits, last_inj_ff, 1'b0};
  wire [31:0] rd_mux = sel_sts ? sts_word : 32'h0000_0000;

  // payload lookup: word and lane of the requested byte
  wire idx_hit = (byte_idx >= `CFTT_FIRST_BYTE) && (byte_idx <= `CFTT_LAST_BYTE);
  wire [5:0] idx_rel = byte_idx - `CFTT_FIRST_BYTE;
  wire [2:0] rd_word = idx_rel[4:2];
  wire [1:0] in_word = idx_rel[1:0];
  // ascending lanes for every word but the one at 0x44
  // word 0x44 keeps its own order: lanes 0,3,2,1 for bytes 53..56
  wire [1:0] lane = (rd_word == `CFTT_WORD_SWIZZLED) ? (2'h0 - in_word) : in_word;
  wire [31:0] sel_word = pay_mem[rd_word];
  wire [7:0] sel_byte = sel_word[8*lane +: 8];

  // injection applies only while a transmitted frame is under way
  wire tx_now = (state_ff == cftt_pkg::CFTT_TX_FRAME);
  wire [4:0] prm = snap_ff.injection_parameter;
  // bit position from the parameter, folded into each field width
  wire [1:0] stc_pos = prm[1:0];
  wire [4:0] crc_pos = (prm >= `CFTT_CRC_W_5) ? (prm - `CFTT_CRC_W_5) : prm;
  wire [`CFTT_DLC_W-1:0] dlc_sub = prm[`CFTT_DLC_W-1:0];
  wire [`CFTT_STC_W-1:0] stc_mask = `CFTT_STC_W'(1) << stc_pos;
  wire [`CFTT_CRC_W-1:0] crc_mask = `CFTT_CRC_W'(1) << crc_pos;
  wire do_stc = tx_now && snap_ff.stuff_count_flip;
  wire do_crc = tx_now && snap_ff.crc_bit_flip;
  wire do_dlc = tx_now && snap_ff.length_code_swap;
  cftt_pkg::cftt_fields_t fld_mod;
  assign fld_mod.stuff_count = do_stc ? (fld_in.stuff_count ^ stc_mask) :
                               fld_in.stuff_count;
  assign fld_mod.crc = do_crc ? (fld_in.crc ^ crc_mask) : fld_in.crc;
  assign fld_mod.dlc = do_dlc ? dlc_sub : fld_in.dlc;
  wire any_inj = do_stc || do_crc || do_dlc;

  // frame tracking
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cftt_pkg::CFTT_IDLE:
      begin
        if (frm_start)
          nxt_state = frm_is_tx ? cftt_pkg::CFTT_TX_FRAME : cftt_pkg::CFTT_RX_FRAME;
      end
      cftt_pkg::CFTT_TX_FRAME,
      cftt_pkg::CFTT_RX_FRAME:
      begin
        if (frm_end)
          nxt_state = cftt_pkg::CFTT_IDLE;
      end
      default:
        nxt_state = cftt_pkg::CFTT_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (wr_pay)
      pay_mem[pay_wsel] <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= cftt_pkg::CFTT_IDLE;
      inj_ff <= '0;
      snap_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (wr_inj)
        inj_ff <= {reg_wdata[`CFTT_PRM_MSB:`CFTT_PRM_LSB], reg_wdata[`CFTT_BIT_DLC_SWAP],
                   reg_wdata[`CFTT_BIT_CRC_FLIP], reg_wdata[`CFTT_BIT_STC_FLIP]};
      if (frm_start && (state_ff == cftt_pkg::CFTT_IDLE))
        snap_ff <= inj_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_ff <= '0;
    else
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      byte_valid_ff <= 1'b0;
      byte_hit_ff <= 1'b0;
      byte_data_ff <= '0;
    end
    else
    begin
      byte_valid_ff <= byte_req;
      byte_hit_ff <= byte_req && idx_hit;
      byte_data_ff <= (byte_req && idx_hit) ? sel_byte : 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fld_valid_ff <= 1'b0;
      fld_ff <= '0;
      last_inj_ff <= 1'b0;
      inj_cnt_ff <= '0;
    end
    else
    begin
      fld_valid_ff <= fld_valid;
      if (fld_valid)
      begin
        fld_ff <= fld_mod;
        last_inj_ff <= any_inj;
        if (any_inj)
          inj_cnt_ff <= inj_cnt_ff + `CFTT_CNT_W'(1);
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign byte_valid = byte_valid_ff;
  assign byte_hit = byte_hit_ff;
  assign byte_data = byte_data_ff;
  assign fld_out_valid = fld_valid_ff;
  assign fld_out = fld_ff;
endmodule

/* cftt_frame_tail_monitor.sv */
// port timing checker of the frame tail block
module cftt_frame_tail_monitor
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic byte_req,
  input wire logic [5:0] byte_idx,
  input wire logic byte_valid,
  input wire logic byte_hit,
  input wire logic [7:0] byte_data,
  input wire logic fld_valid,
  input wire logic fld_out_valid,
  input wire cftt_pkg::cftt_fields_t fld_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_byte_answer: assert property (byte_valid == $past(byte_req))
    else $error("byte answer timing");
  chk_byte_hit: assert property (byte_req && byte_idx >= 6'h2c |=> byte_hit)
    else $error("byte hit missing");
  chk_byte_miss: assert property (byte_req && byte_idx < 6'h2c |=> !byte_hit)
    else $error("byte hit outside range");
  chk_miss_data: assert property (byte_valid && !byte_hit |-> byte_data == 8'h0)
    else $error("miss data not zero");
  chk_wo_read: assert property (reg_rd && reg_addr inside {[8'h3c:8'h50]} |=> reg_rdata == 0)
    else $error("write-only word read back");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside slot");
  chk_fld_answer: assert property (fld_out_valid == $past(fld_valid))
    else $error("field answer timing");
  chk_fld_hold: assert property (!fld_valid |=> $stable(fld_out))
    else $error("fields changed unasked");
  cover property (byte_req && byte_idx == 6'h3f);
  cover property (byte_req && byte_idx == 6'h2b);
  cover property (fld_valid);
endmodule
bind cftt_frame_tail cftt_frame_tail_monitor i_mon (.clk, .srst, .reg_addr, .reg_rd, .reg_rdata,
  .byte_req, .byte_idx, .byte_valid, .byte_hit, .byte_data, .fld_valid, .fld_out_valid, .fld_out);

/* cftt_engine_model.sv */
// protocol engine model: start, one field hand-over, end
module cftt_engine_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  output logic frm_start,
  output logic fld_valid,
  output logic frm_end,
  output cftt_pkg::cftt_fields_t fld_in
);
  logic [2:0] step_ff;
  always_ff @(posedge clk)
    step_ff <= srst ? 3'h0 : go ? 3'h1 : step_ff << 1;
  assign frm_start = step_ff[0];
  assign fld_valid = step_ff[1];
  assign frm_end = step_ff[2];
  // fields inverted outside the valid cycle
  assign fld_in = fld_valid ? 29'h3 : ~29'h3;
endmodule

/* tb_cftt_frame_tail.sv */
// self-checking bench of the frame tail block
module tb_cftt_frame_tail;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, byte_req = 0, go = 0, tx = 0;
  logic [7:0] reg_addr = 0, byte_data;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [5:0] byte_idx = 0;
  logic frm_start, frm_end, fld_valid, byte_valid, byte_hit, fld_out_valid;
  cftt_pkg::cftt_fields_t fld_in, fld_out;
  int fail_count = 0, n_compared = 0;
  initial forever #5 clk = ~clk;
  cftt_engine_model i_eng (.clk, .srst, .go, .frm_start, .fld_valid, .frm_end, .fld_in);
  cftt_frame_tail i_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frm_start, .frm_is_tx(tx), .frm_end, .byte_req, .byte_idx, .byte_valid, .byte_hit,
    .byte_data, .fld_valid, .fld_in, .fld_out_valid, .fld_out);
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd0(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, 32'h0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic bq(input logic [5:0] i, input logic [9:0] exp);
    @(posedge clk);
    byte_idx <= i;
    byte_req <= 1'h1;
    @(posedge clk);
    byte_req <= 1'h0;
    #1 check({byte_valid, byte_hit, byte_data}, exp);
  endtask
  task automatic frame(input logic t, input logic [28:0] exp);
    int i;
    @(posedge clk);
    go <= 1'h1;
    tx <= t;
    @(posedge clk);
    go <= 1'h0;
    for (i = 0; i < 8 && fld_out_valid !== 1'h1; i++)
      @(posedge clk) #1;
    if (i == 8)
    begin
      fail_count++;
      give_verdict;
    end
    check(32'(fld_out), 32'(exp));
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    for (int k = 0; k < 5; k++)
      wr(8'h3c + 8'(4 * k), k == 2 ? 32'h36373835 : {8'(48 + 4 * k), 8'(47 + 4 * k),
        8'(46 + 4 * k), 8'(45 + 4 * k)});
    for (int n = 45; n < 65; n++)
      bq(6'(n - 1), {2'h3, 8'(n)});
    bq(6'h2b, 10'h200);
    frame(1'h1, {4'h0, 21'h0, 4'h3});
    wr(8'h50, 32'h1607);
    frame(1'h0, {4'h0, 21'h0, 4'h3});
    frame(1'h1, {4'h4, 21'h2, 4'h6});
    wr(8'h50, 32'h0302);
    frame(1'h1, {4'h0, 21'h8, 4'h3});
    rdx(8'h54, 32'h0000_0202);
    rd0(8'h44);
    rd0(8'h50);
    wr(8'h80, 32'hffffffff);
    rd0(8'h80);
    give_verdict;
  end
endmodule
